//--- rtl/plc_pkg.sv
/*
  Constants for the lamp mode and interrupt control register bank.
  Assumes a 16-bit management register port decoded by register index.
*/
package plc_pkg;
  localparam logic [4:0] PLC_IDX_LAMP = 5'h14;
  localparam logic [4:0] PLC_IDX_RSVD = 5'h15;
  localparam logic [4:0] PLC_IDX_IRQ_CTRL = 5'h16;
  localparam logic [4:0] PLC_IDX_IRQ_FLAGS = 5'h17;
  localparam logic [15:0] PLC_LAMP_RST = 16'h3FE9;
  localparam logic [15:0] PLC_RSVD_RST = 16'h0000;
  localparam logic [15:0] PLC_IRQ_CTRL_RST = 16'h0000;
  localparam logic [10:0] PLC_FLAGS_RST = 11'h000;
  localparam int PLC_LAMP_B_LSB = 3;
  localparam int PLC_LAMP_A_LSB = 0;
  localparam int PLC_OUT_EN_BIT = 15;
  localparam int PLC_RD_CLR_BIT = 14;
  localparam int PLC_POL_BIT = 13;
  localparam int PLC_AUTO_CLR_BIT = 12;
  localparam int PLC_RESETUP_BIT = 11;
  localparam int PLC_NUM_EVENTS = 11;
  localparam logic [2:0] PLC_MODE_LINK = 3'h0;
  localparam logic [2:0] PLC_MODE_ACT = 3'h1;
  localparam logic [2:0] PLC_MODE_TX = 3'h2;
  localparam logic [2:0] PLC_MODE_RX = 3'h3;
  localparam logic [2:0] PLC_MODE_COL = 3'h4;
  localparam logic [2:0] PLC_MODE_SPEED = 3'h5;
  localparam logic [2:0] PLC_MODE_FDX = 3'h6;
  localparam logic [2:0] PLC_MODE_LAST = 3'h7;
endpackage

//--- rtl/plc_lamp_mux.sv
/*
  Lamp source selector: picks one line status per 3-bit mode code.
  Assumes status inputs are already in the management clock domain.
*/
`timescale 1ns/1ns
module plc_lamp_mux
  import plc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [2:0] mode_i,
  input wire logic last_is_link_i,
  input wire logic [6:0] status_i,
  output logic lamp_o
);
  logic lamp_q;
  logic lamp_d;

  always_comb begin
    lamp_d = 1'b0;
    case (mode_i)
      PLC_MODE_LINK: lamp_d = status_i[0];
      PLC_MODE_ACT: lamp_d = status_i[1];
      PLC_MODE_TX: lamp_d = status_i[2];
      PLC_MODE_RX: lamp_d = status_i[3];
      PLC_MODE_COL: lamp_d = status_i[4];
      PLC_MODE_SPEED: lamp_d = status_i[5];
      PLC_MODE_FDX: lamp_d = status_i[6];
      // Lamp a reuses the last code for link, lamp b goes dark
      PLC_MODE_LAST: lamp_d = last_is_link_i & status_i[0];
      default: lamp_d = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      lamp_q <= 1'b0;
    end else begin
      lamp_q <= lamp_d;
    end
  end

  assign lamp_o = lamp_q;
endmodule

//--- rtl/plc_top.sv
/*
  Lamp mode and interrupt control register bank of a management register file.
  Assumes a single-cycle register port from the serial management engine and
  event/condition inputs synchronous to clk_i (conditions are levels, events pulses).
*/
//
// Behaviour
// - Lamp b mode selects source, default speed
// - Lamp a same codes, default activity, 111 link
// - Irq pin driven only if enabled, polarity
// - Clear-on-read enable clears flags on read
// - Auto-clear drops flag when condition ends
// - Write one clears, unless re-setup and condition
// - Enables for wake, sleep entry, autoneg done
// - Enables for eight link events, reset zero
// - Status register holds one flag per event
`timescale 1ns/1ns
module plc_top
  import plc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [4:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [15:0] reg_wdata_i,
  output logic [15:0] reg_rdata_o,
  input wire logic [10:0] event_i,
  input wire logic [10:0] cond_i,
  input wire logic [6:0] line_status_i,
  output logic status_lamp_a_o,
  output logic status_lamp_b_o,
  output logic irq_o,
  output logic irq_oe_o
);
  logic [15:0] lamp_q, lamp_d;
  logic [15:0] rsvd_q, rsvd_d;
  logic [15:0] ctrl_q, ctrl_d;
  logic [10:0] flags_q, flags_d;
  logic [15:0] rdata_q, rdata_d;
  logic irq_q, irq_d, oe_q, oe_d;

  function automatic logic hit(input logic [4:0] a, input logic [4:0] idx);
    hit = (a == idx);
  endfunction

  always_comb begin
    lamp_d = lamp_q;
    rsvd_d = rsvd_q;
    ctrl_d = ctrl_q;
    flags_d = flags_q;
    rdata_d = rdata_q;
    if (reg_wr_i && hit(reg_addr_i, PLC_IDX_LAMP)) begin
      lamp_d = reg_wdata_i;
    end
    if (reg_wr_i && hit(reg_addr_i, PLC_IDX_RSVD)) begin
      rsvd_d = reg_wdata_i;
    end
    if (reg_wr_i && hit(reg_addr_i, PLC_IDX_IRQ_CTRL)) begin
      ctrl_d = reg_wdata_i;
    end
    if (reg_rd_i) begin
      case (reg_addr_i)
        PLC_IDX_LAMP: rdata_d = lamp_q;
        PLC_IDX_RSVD: rdata_d = rsvd_q;
        PLC_IDX_IRQ_CTRL: rdata_d = ctrl_q;
        PLC_IDX_IRQ_FLAGS: rdata_d = {5'h00, flags_q};
        default: rdata_d = 16'h0000;
      endcase
    end
    // Clears first, then new events, so a same-cycle event is never lost
    if (reg_rd_i && hit(reg_addr_i, PLC_IDX_IRQ_FLAGS) && ctrl_q[PLC_RD_CLR_BIT]) begin
      flags_d = 11'h000;
    end
    if (reg_wr_i && hit(reg_addr_i, PLC_IDX_IRQ_FLAGS)) begin
      if (ctrl_q[PLC_RESETUP_BIT]) begin
        flags_d = flags_d & ~(reg_wdata_i[10:0] & ~cond_i);
      end else begin
        flags_d = flags_d & ~reg_wdata_i[10:0];
      end
    end
    if (ctrl_q[PLC_AUTO_CLR_BIT]) begin
      flags_d = flags_d & cond_i;
    end
    flags_d = flags_d | event_i;
  end

  always_comb begin
    irq_d = |(flags_q & ctrl_q[10:0]) && ctrl_q[PLC_OUT_EN_BIT];
    irq_d = ctrl_q[PLC_POL_BIT] ? irq_d : ~irq_d;
    oe_d = ctrl_q[PLC_OUT_EN_BIT];
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      lamp_q <= PLC_LAMP_RST;
      rsvd_q <= PLC_RSVD_RST;
      ctrl_q <= PLC_IRQ_CTRL_RST;
      flags_q <= PLC_FLAGS_RST;
      rdata_q <= 16'h0000;
      irq_q <= 1'b1;
      oe_q <= 1'b0;
    end else begin
      lamp_q <= lamp_d;
      rsvd_q <= rsvd_d;
      ctrl_q <= ctrl_d;
      flags_q <= flags_d;
      rdata_q <= rdata_d;
      irq_q <= irq_d;
      oe_q <= oe_d;
    end
  end

  plc_lamp_mux u_lamp_b (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .mode_i(lamp_q[PLC_LAMP_B_LSB+2:PLC_LAMP_B_LSB]),
    .last_is_link_i(1'b0),
    .status_i(line_status_i),
    .lamp_o(status_lamp_b_o)
  );

  plc_lamp_mux u_lamp_a (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .mode_i(lamp_q[PLC_LAMP_A_LSB+2:PLC_LAMP_A_LSB]),
    .last_is_link_i(1'b1),
    .status_i(line_status_i),
    .lamp_o(status_lamp_a_o)
  );

  assign reg_rdata_o = rdata_q;
  assign irq_o = irq_q;
  assign irq_oe_o = oe_q;
endmodule

//--- verif/plc_top_sva.sv
/* Port checker for plc_top.
   Assumes the bind below and a 16-bit register port. */
`timescale 1ns/1ns
module plc_top_sva (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [4:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic [6:0] line_status_i,
  input wire logic status_lamp_a_o,
  input wire logic status_lamp_b_o,
  input wire logic irq_o,
  input wire logic irq_oe_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_ctrl_wr;
    reg_wr_i && reg_addr_i == 5'h16;
  endsequence
  sequence s_lamp_wr;
    reg_wr_i && reg_addr_i == 5'h14;
  endsequence
  chk_oe_follows: assert property (s_ctrl_wr |-> ##2 irq_oe_o == $past(reg_wdata_i[15], 2))
    else $error("pin enable wrong");
  // Undriven pin must rest at the inactive level of the chosen polarity
  chk_irq_idle: assert property (s_ctrl_wr ##0 !reg_wdata_i[15] |-> ##2 irq_o == !$past(reg_wdata_i[13], 2))
    else $error("idle level wrong");
  chk_lamp_b_off: assert property (s_lamp_wr ##0 reg_wdata_i[5:3] == 3'h7 |-> ##2 !status_lamp_b_o)
    else $error("lamp b not off");
  chk_lamp_b_speed: assert property (s_lamp_wr ##0 reg_wdata_i[5:3] == 3'h5 |-> ##2 status_lamp_b_o == $past(line_status_i[5]))
    else $error("lamp b speed wrong");
  chk_lamp_a_link: assert property (s_lamp_wr ##0 reg_wdata_i[2:0] == 3'h7 |-> ##2 status_lamp_a_o == $past(line_status_i[0]))
    else $error("lamp a link wrong");
  chk_unmapped_zero: assert property (reg_rd_i && reg_addr_i < 5'h14 |=> reg_rdata_o == 16'h0000)
    else $error("unmapped read");
  chk_rdata_hold: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data moved");
  chk_flag_top_zero: assert property (reg_rd_i && reg_addr_i == 5'h17 |=> reg_rdata_o[15:11] == 5'h00)
    else $error("flag upper bits");
endmodule
bind plc_top plc_top_sva plc_top_sva_i (.*);

//--- verif/plc_sta_model.sv
/* Station manager model: one register access per call.
   Assumes read data is registered one cycle after the strobe. */
`timescale 1ns/1ns
module plc_sta_model (
  input wire logic clk_i,
  input wire logic [15:0] reg_rdata_o,
  output logic [4:0] reg_addr_i = 5'h00,
  output logic reg_wr_i = 1'b0,
  output logic reg_rd_i = 1'b0,
  output logic [15:0] reg_wdata_i = 16'h0000
);
  task automatic acc(input logic w, input logic [4:0] a, input logic [15:0] d, output logic [15:0] q);
    @(negedge clk_i);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = w;
    reg_rd_i = !w;
    @(negedge clk_i);
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    // Released data is inverted so a stale value never looks valid
    reg_wdata_i = ~d;
    q = reg_rdata_o;
  endtask
endmodule

//--- verif/tb_top.sv
/* Bench for plc_top, driven through the manager model.
   Assumes the checker binds itself. */
`timescale 1ns/1ns
module tb_top;
  import plc_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [10:0] event_i = 11'h000;
  logic [10:0] cond_i = 11'h000;
  logic [6:0] line_status_i = 7'h20;
  logic [4:0] reg_addr_i;
  logic reg_wr_i, reg_rd_i, status_lamp_a_o, status_lamp_b_o, irq_o, irq_oe_o;
  logic [15:0] reg_wdata_i, reg_rdata_o, q;
  int n_errors = 0, checks = 0, cyc = 0;
  always #50 clk_i = ~clk_i;
  plc_top plc_top_i (.*);
  plc_sta_model plc_sta_model_i (.*);
  task automatic cmp(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("FAIL %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    plc_sta_model_i.acc(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    plc_sta_model_i.acc(1'b0, a, 16'h0000, q);
    cmp(q, e);
  endtask
  task automatic ev(input logic [10:0] b);
    @(negedge clk_i);
    event_i = b;
    @(negedge clk_i);
    event_i = 11'h000;
    @(negedge clk_i);
  endtask
  task automatic t_reset;
    rd(PLC_IDX_LAMP, PLC_LAMP_RST);
    rd(PLC_IDX_IRQ_CTRL, 16'h0000);
    rd(PLC_IDX_IRQ_FLAGS, 16'h0000);
    rd(5'h03, 16'h0000);
    cmp({status_lamp_b_o, status_lamp_a_o, irq_o, irq_oe_o}, 16'hA);
  endtask
  task automatic t_lamp;
    for (int c = 0; c < 8; c++) begin
      line_status_i = (c == 7) ? 7'h01 : 7'h01 << c;
      wr(PLC_IDX_LAMP, 16'h3FC0 | 16'(c * 9));
      @(negedge clk_i);
      cmp({status_lamp_b_o, status_lamp_a_o}, {c != 7, 1'b1});
    end
  endtask
  task automatic t_irq;
    wr(PLC_IDX_IRQ_CTRL, 16'h8001);
    ev(11'h400);
    cmp({irq_oe_o, irq_o}, 16'h3);
    ev(11'h001);
    cmp({irq_oe_o, irq_o}, 16'h2);
    rd(PLC_IDX_IRQ_FLAGS, 16'h0401);
    rd(PLC_IDX_IRQ_FLAGS, 16'h0401);
    wr(PLC_IDX_IRQ_CTRL, 16'hE001);
    rd(PLC_IDX_IRQ_FLAGS, 16'h0401);
    rd(PLC_IDX_IRQ_FLAGS, 16'h0000);
    ev(11'h001);
    cmp({irq_oe_o, irq_o}, 16'h3);
    wr(PLC_IDX_IRQ_FLAGS, 16'h0001);
    rd(PLC_IDX_IRQ_FLAGS, 16'h0000);
    wr(PLC_IDX_IRQ_CTRL, 16'hA801);
    cond_i = 11'h001;
    ev(11'h001);
    wr(PLC_IDX_IRQ_FLAGS, 16'h0001);
    rd(PLC_IDX_IRQ_FLAGS, 16'h0001);
    wr(PLC_IDX_IRQ_CTRL, 16'h9001);
    rd(PLC_IDX_IRQ_FLAGS, 16'h0001);
    cond_i = 11'h000;
    @(negedge clk_i);
    rd(PLC_IDX_IRQ_FLAGS, 16'h0000);
    wr(PLC_IDX_IRQ_CTRL, 16'h0001);
    @(negedge clk_i);
    cmp({irq_oe_o, irq_o}, 16'h1);
  endtask
  task automatic results;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 2000) begin
      n_errors++;
      results();
    end
  end
  initial begin
    repeat (12) @(negedge clk_i);
    rst_n_i = 1'b1;
    t_reset();
    t_lamp();
    t_irq();
    results();
  end
endmodule
